// file: core/sbc_blk_gate.sv
/*
  Reset, clock and write gating for one peripheral from its disable bit.
  Assumes the peripheral returns initial values while its reset is held.
*/
`timescale 1ns/10ps
module sbc_blk_gate (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Disable bit.
  input wire logic off_i,
  // Peripheral controls.
  output logic blk_rst_n_o,
  output logic clk_en_o,
  output logic wr_en_o
);
  typedef struct packed {
    logic rst_n;
    logic clk_en;
    logic wr_en;
  } sbc_gate_st_t;

  sbc_gate_st_t st;
  sbc_gate_st_t next_st;

  // All three follow the disable bit, so the peripheral sees one clean change.
  always_comb begin
    next_st.rst_n = !off_i;
    next_st.clk_en = !off_i;
    next_st.wr_en = !off_i;
  end

  // System reset holds the peripheral in reset as well.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign blk_rst_n_o = st.rst_n;
  assign clk_en_o = st.clk_en;
  assign wr_en_o = st.wr_en;
endmodule : sbc_blk_gate

// file: core/sbc_ctrl.sv
/*
  Standby and block power controller: run, HALT and STOP modes, the
  two-write stop unlock, wake-up handling and per-peripheral disables,
  reached as an AHB-Lite slave.
  Assumes one clock, inputs synchronous to it, irq_pending_i high whenever
  some interrupt has both enable and request set (whatever the master
  enable), and ls_tick_i pulsing once per low-speed clock period.
  hsize_i is ignored: every access is taken as one aligned word. The halt
  bit clears on the next rising edge, since the block uses one edge only.
*/
// Notes on behaviour
// [R1] The unlock key register is write-only and always reads zero.
// [R2] Unlock arms after a write with upper nibble 5 then one with A.
// [R3] Other activity between the two key writes does not break the sequence.
// [R4] Any other value after the first code discards it; restart needed.
// [R5] Writing the stop bit while armed moves the device into STOP.
// [R6] STOP stops both oscillators, halting the CPU and peripherals.
// [R7] Entering STOP disarms the unlock, so each STOP needs a new unlock.
// [R8] System reset leaves the unlock disarmed.
// [R9] Unlock cannot arm while any enabled interrupt request is pending.
// [R10] An enabled interrupt during STOP clears the stop bit and resumes run.
// [R11] Writing the halt bit enters HALT; CPU stops, peripherals run.
// [R12] Watchdog or enabled interrupt ends HALT and clears the halt bit.
// [R13] Standby bits: 00 run, 01 HALT, 10 STOP, 11 prohibited.
// [R14] HALT or STOP is refused while an enabled interrupt is pending.
// [R15] Wake with master enable clear releases without interrupt service; a watchdog HALT wake here still asks service.
// [R16] A set disable bit holds its peripheral in reset and stops its clock.
// [R17] While disabled, peripheral writes are blocked and reads give initials.
// [R18] Software clears the disable bit before using the peripheral.
// [R19] Serial disable bit 2 turns off the first UART; reset leaves it on.
// [R20] Converter disable bit 0 resets and switches off the SAR converter.
// [R21] Timer disable bits 7,6,3,2,1,0; bits 5 and 4 read zero.
// [R22] A HALT wake clears the halt bit at the next system clock.
// [R23] Low-speed STOP wake counts 32 low-speed ticks before release.
// [R24] STOP takes effect two cycles after the stop-bit write.
// [R25] Writing both standby bits at once leaves the mode unchanged.
`timescale 1ns/10ps
module sbc_ctrl #(
  parameter int LS_TICKS = sbc_pkg::LS_WAKE_TICKS
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // AHB-Lite slave.
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Interrupt and clock status.
  input wire logic irq_pending_i,
  input wire logic wdt_irq_i,
  input wire logic master_irq_enable_i,
  input wire logic ls_tick_i,
  // Mode outputs.
  output logic cpu_halt_o,
  output logic osc_stop_o,
  output logic periph_clk_on_o,
  output logic wake_o,
  output logic irq_service_o,
  // Peripheral gating, index 0 UART0, 1 SAR, 2..7 timers 8,9,A,B,E,F, 8 PWM.
  output logic [sbc_pkg::NUM_BLK-1:0] blk_rst_n_o,
  output logic [sbc_pkg::NUM_BLK-1:0] blk_clk_en_o,
  output logic [sbc_pkg::NUM_BLK-1:0] blk_wr_en_o
);
  // Controller state other than the reset flops, wake counter and gates sits in one flop bank, filled by one comb block.
  typedef struct packed {
    logic ready;
    logic resp;
    logic dp_wr;
    logic [15:0] dp_idx;
    logic [31:0] rdata;
    logic first;
    logic armed;
    sbc_pkg::sbc_mode_t mode;
    logic [1:0] ent_cnt;
    logic [7:0] ser;
    logic [7:0] conv;
    logic [7:0] tmr;
    logic [7:0] pwm;
    logic cfg_ls;
    logic wake;
    logic svc;
    logic cpu_halt;
    logic osc_stop;
    logic clk_on;
  } sbc_core_st_t;

  sbc_core_st_t st;
  sbc_core_st_t next_st;
  logic [1:0] rst_q;
  logic rst_n;
  logic tick_start;
  logic tick_done;
  logic [sbc_pkg::NUM_BLK-1:0] off_vec;

  // The wake counter holds at most 256 ticks.
  if (LS_TICKS < 1 || LS_TICKS > 256) begin : g_bad
    $error("sbc_ctrl: LS_TICKS out of range");
  end

  // Reset is asserted at once and released through two flops.
  // Only the second flop feeds the design, so release never meets a metastable flop.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Read view of a register after this cycle's write has been applied.
  // Status and config are local additions; only config bit zero is writable.
  function automatic logic [31:0] read_reg(input logic [15:0] idx,
                                           input sbc_core_st_t s);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (idx == sbc_pkg::IDX_KEY) begin
      d = 32'h0000_0000; // [R1]
    end else if (idx == sbc_pkg::IDX_SBY) begin
      d = 32'h0000_0000;
    end else if (idx == sbc_pkg::IDX_SER) begin
      d[7:0] = s.ser;
    end else if (idx == sbc_pkg::IDX_CONV) begin
      d[7:0] = s.conv;
    end else if (idx == sbc_pkg::IDX_TMR) begin
      d[7:0] = s.tmr; // [R21]
    end else if (idx == sbc_pkg::IDX_PWM) begin
      d[7:0] = s.pwm;
    end else if (idx == sbc_pkg::IDX_STAT) begin
      d[sbc_pkg::STAT_ARMED] = s.armed;
      d[sbc_pkg::STAT_FIRST] = s.first;
      d[sbc_pkg::STAT_HALT] = (s.mode == sbc_pkg::MODE_HALT);
      d[sbc_pkg::STAT_STOP] = (s.mode == sbc_pkg::MODE_STOP) ||
                              (s.mode == sbc_pkg::MODE_STOP_PEND);
      d[sbc_pkg::STAT_WAKE] = (s.mode == sbc_pkg::MODE_WAKE);
    end else if (idx == sbc_pkg::IDX_CFG) begin
      d[sbc_pkg::CFG_LOW_SPEED] = s.cfg_ls;
    end
    return d;
  endfunction : read_reg

  // Bus side, unlock, standby writes and the mode machine.
  // Only the low byte of hwdata carries data; the upper bits are ignored.
  always_comb begin
    logic [7:0] wd;
    logic rel;
    wd = hwdata_i[7:0];
    rel = 1'b0;
    next_st = st;
    next_st.wake = 1'b0;
    next_st.svc = 1'b0;
    tick_start = 1'b0;

    // Data phase of a write: the address was captured one edge earlier.
    if (st.dp_wr) begin
      if (st.dp_idx == sbc_pkg::IDX_KEY) begin
        // Only the upper nibble of a key write counts; the lower one is free.
        if (wd[7:4] == sbc_pkg::KEY_FIRST) begin
          next_st.first = 1'b1; // [R2] [R3]
        end else if (wd[7:4] == sbc_pkg::KEY_SECOND && st.first) begin
          next_st.first = 1'b0;
          next_st.armed = !irq_pending_i; // [R2] [R9]
        end else begin
          next_st.first = 1'b0; // [R4]
        end
      end else if (st.dp_idx == sbc_pkg::IDX_SBY) begin
        // Writes count only in run mode; MODE_STOP_PEND and the other modes ignore them.
        // A pending enabled interrupt would wake at once, so the request is dropped.
        if (st.mode == sbc_pkg::MODE_RUN && !irq_pending_i) begin // [R14]
          case (wd[1:0]) // [R13]
            2'h1: begin
              next_st.mode = sbc_pkg::MODE_HALT; // [R11]
            end
            2'h2: begin
              if (st.armed) begin
                next_st.mode = sbc_pkg::MODE_STOP_PEND; // [R5]
                next_st.ent_cnt = sbc_pkg::STOP_ENTRY_CYC - 2'h1; // [R24]
                // Disarming here lets a key write in the pending cycles arm
                // the next entry rather than being wiped by this one.
                next_st.armed = 1'b0; // [R7]
                next_st.first = 1'b0;
              end
            end
            default: begin
              next_st.mode = st.mode; // [R25]
            end
          endcase
        end
      end else if (st.dp_idx == sbc_pkg::IDX_SER) begin
        next_st.ser = wd & sbc_pkg::MASK_SER; // [R19]
      end else if (st.dp_idx == sbc_pkg::IDX_CONV) begin
        next_st.conv = wd & sbc_pkg::MASK_CONV; // [R20]
      end else if (st.dp_idx == sbc_pkg::IDX_TMR) begin
        next_st.tmr = wd & sbc_pkg::MASK_TMR; // [R21]
      end else if (st.dp_idx == sbc_pkg::IDX_PWM) begin
        next_st.pwm = wd & sbc_pkg::MASK_PWM;
      end else if (st.dp_idx == sbc_pkg::IDX_CFG) begin
        next_st.cfg_ls = wd[sbc_pkg::CFG_LOW_SPEED];
      end
    end

    // Mode sequencing. Every wake leaves through run mode with a one-cycle
    // wake pulse; a masked interrupt still wakes the core but, unless it is the watchdog, asks no service.
    case (st.mode)
      sbc_pkg::MODE_STOP_PEND: begin
        // The CPU may still run a couple of instructions in these cycles.
        if (st.ent_cnt == 2'h0) begin
          next_st.mode = sbc_pkg::MODE_STOP; // [R24]
        end else begin
          next_st.ent_cnt = st.ent_cnt - 2'h1;
        end
      end
      sbc_pkg::MODE_HALT: begin
        // A watchdog request ends HALT whether or not it is masked.
        if (wdt_irq_i || irq_pending_i) begin
          next_st.mode = sbc_pkg::MODE_RUN; // [R12] [R22]
          next_st.svc = wdt_irq_i || master_irq_enable_i; // [R15]
          rel = 1'b1;
        end
      end
      sbc_pkg::MODE_STOP: begin
        if (irq_pending_i) begin
          if (st.cfg_ls) begin
            next_st.mode = sbc_pkg::MODE_WAKE; // [R23]
            tick_start = 1'b1;
          end else begin
            next_st.mode = sbc_pkg::MODE_RUN; // [R10]
            next_st.svc = master_irq_enable_i; // [R15]
            rel = 1'b1;
          end
        end
      end
      sbc_pkg::MODE_WAKE: begin
        // Peripherals stay unclocked until the low-speed count runs out.
        if (tick_done) begin
          next_st.mode = sbc_pkg::MODE_RUN; // [R10] [R23]
          next_st.svc = master_irq_enable_i; // [R15]
          rel = 1'b1;
        end
      end
      default: begin
        // Keep the entry count that this cycle's stop write has just loaded.
        if (next_st.mode != sbc_pkg::MODE_STOP_PEND) begin
          next_st.ent_cnt = 2'h0;
        end
      end
    endcase
    next_st.wake = rel;

    // Clock and CPU controls follow the next mode.
    next_st.cpu_halt = (next_st.mode != sbc_pkg::MODE_RUN) &&
                       (next_st.mode != sbc_pkg::MODE_STOP_PEND);
    next_st.osc_stop = (next_st.mode == sbc_pkg::MODE_STOP); // [R6]
    next_st.clk_on = (next_st.mode != sbc_pkg::MODE_STOP) &&
                     (next_st.mode != sbc_pkg::MODE_WAKE); // [R6] [R23]

    // Address phase: zero wait states, read data is ready in the data phase.
    // hreadyout never drops, so the master never has to wait on this block.
    next_st.ready = 1'b1;
    next_st.resp = 1'b0;
    next_st.dp_wr = 1'b0;
    if (hsel_i && htrans_i[1] && hready_i) begin
      next_st.dp_idx = (haddr_i[31:18] == 14'h0000) ? haddr_i[17:2] : 16'h0000;
      next_st.dp_wr = hwrite_i;
      if (!hwrite_i) begin
        next_st.rdata = read_reg(next_st.dp_idx, next_st);
      end
    end
  end

  // All control state; reset disarms the unlock and selects run mode.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0; // [R8]
      st.ready <= 1'b1;
      st.mode <= sbc_pkg::MODE_RUN;
      st.ser <= sbc_pkg::RST_BLK;
      st.conv <= sbc_pkg::RST_BLK;
      st.tmr <= sbc_pkg::RST_BLK;
      st.pwm <= sbc_pkg::RST_BLK;
      st.cfg_ls <= sbc_pkg::CFG_RST;
      st.clk_on <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Low-speed wake counter.
  // It is only started from STOP with the low-speed option selected.
  sbc_tick_cnt #(
    .TICKS(LS_TICKS)
  ) u_wake_cnt (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .start_i(tick_start),
    .tick_i(ls_tick_i),
    .done_o(tick_done)
  );

  // Disable bits gathered in output order.
  // Reserved timer bits five and four never reach a gate.
  assign off_vec = {st.pwm[sbc_pkg::BIT_PWM],
                    st.tmr[sbc_pkg::BIT_TMR_F],
                    st.tmr[sbc_pkg::BIT_TMR_E],
                    st.tmr[sbc_pkg::BIT_TMR_B],
                    st.tmr[sbc_pkg::BIT_TMR_A],
                    st.tmr[sbc_pkg::BIT_TMR_9],
                    st.tmr[sbc_pkg::BIT_TMR_8],
                    st.conv[sbc_pkg::BIT_SAR],
                    st.ser[sbc_pkg::BIT_UART0]};

  // One gate per peripheral; a cleared bit releases it again.
  // Each gate adds one flop, so a peripheral follows its bit one edge later.
  for (genvar g = 0; g < sbc_pkg::NUM_BLK; g++) begin : g_blk
    sbc_blk_gate u_gate (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .off_i(off_vec[g]), // [R16] [R18]
      .blk_rst_n_o(blk_rst_n_o[g]),
      .clk_en_o(blk_clk_en_o[g]),
      .wr_en_o(blk_wr_en_o[g]) // [R17]
    );
  end

  // Registered outputs.
  // Every output is a flop, so nothing downstream sees a decode glitch.
  assign hrdata_o = st.rdata;
  assign hreadyout_o = st.ready;
  assign hresp_o = st.resp;
  assign cpu_halt_o = st.cpu_halt;
  assign osc_stop_o = st.osc_stop;
  assign periph_clk_on_o = st.clk_on;
  assign wake_o = st.wake;
  assign irq_service_o = st.svc;
endmodule : sbc_ctrl

// file: core/sbc_pkg.sv
/*
  Constants for the standby and block power controller: register indices,
  field positions, write masks, reset values, timing counts and the mode type.
  Assumes a byte-wide register set whose indices sit on a word-wide bus.
*/
package sbc_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [15:0] IDX_KEY = 16'hF008;
  localparam logic [15:0] IDX_SBY = 16'hF009;
  localparam logic [15:0] IDX_SER = 16'hF02A;
  localparam logic [15:0] IDX_CONV = 16'hF02C;
  localparam logic [15:0] IDX_TMR = 16'hF02E;
  localparam logic [15:0] IDX_PWM = 16'hF02F;
  localparam logic [15:0] IDX_STAT = 16'hF030;
  localparam logic [15:0] IDX_CFG = 16'hF031;
  // Unlock codes, upper nibble only.
  localparam logic [3:0] KEY_FIRST = 4'h5;
  localparam logic [3:0] KEY_SECOND = 4'hA;
  // Standby control fields.
  localparam int BIT_HALT = 0;
  localparam int BIT_STOP = 1;
  // Block disable fields.
  localparam int BIT_UART0 = 2;
  localparam int BIT_SAR = 0;
  localparam int BIT_TMR_F = 7;
  localparam int BIT_TMR_E = 6;
  localparam int BIT_TMR_B = 3;
  localparam int BIT_TMR_A = 2;
  localparam int BIT_TMR_9 = 1;
  localparam int BIT_TMR_8 = 0;
  localparam int BIT_PWM = 0;
  localparam logic [7:0] MASK_SER = 8'h04;
  localparam logic [7:0] MASK_CONV = 8'h01;
  localparam logic [7:0] MASK_TMR = 8'hCF;
  localparam logic [7:0] MASK_PWM = 8'h01;
  localparam logic [7:0] RST_BLK = 8'h00;
  // Status and configuration fields.
  localparam int STAT_ARMED = 0;
  localparam int STAT_FIRST = 1;
  localparam int STAT_HALT = 2;
  localparam int STAT_STOP = 3;
  localparam int STAT_WAKE = 4;
  localparam int CFG_LOW_SPEED = 0;
  localparam logic CFG_RST = 1'b0;
  // Timing counts and the number of gated blocks.
  localparam logic [1:0] STOP_ENTRY_CYC = 2'h2;
  localparam int LS_WAKE_TICKS = 32;
  localparam int NUM_BLK = 9;
  // Operating modes.
  typedef enum logic [2:0] {
    MODE_RUN, MODE_STOP_PEND, MODE_HALT, MODE_STOP, MODE_WAKE
  } sbc_mode_t;
endpackage : sbc_pkg

// file: core/sbc_tick_cnt.sv
/*
  Counts a fixed number of low-speed clock ticks after a start pulse.
  Assumes tick_i is a one-cycle pulse synchronous to clk_i.
*/
`timescale 1ns/10ps
module sbc_tick_cnt #(
  parameter int TICKS = 32
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control.
  input wire logic start_i,
  input wire logic tick_i,
  output logic done_o
);
  typedef struct packed {
    logic busy;
    logic [8:0] cnt;
    logic done;
  } sbc_tick_st_t;

  sbc_tick_st_t st;
  sbc_tick_st_t next_st;

  // The range stops at 256 ticks, although the nine-bit count field could count further.
  if (TICKS < 1 || TICKS > 256) begin : g_bad
    $error("sbc_tick_cnt: TICKS out of range");
  end

  // A start restarts the count; done pulses once on the last tick.
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (start_i) begin
      next_st.busy = 1'b1;
      next_st.cnt = 9'h000;
    end else if (st.busy && tick_i) begin
      if (st.cnt == 9'(TICKS - 1)) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 9'h001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done_o = st.done;
endmodule : sbc_tick_cnt

// file: dv/sbc_ctrl_assertions.sv
/*
  Checker for the mode and gating outputs of the controller.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
module sbc_ctrl_chk #(
  parameter int LS_TICKS = 32
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic irq_pending_i,
  input wire logic wdt_irq_i,
  input wire logic master_irq_enable_i,
  input wire logic ls_tick_i,
  input wire logic cpu_halt_o,
  input wire logic osc_stop_o,
  input wire logic periph_clk_on_o,
  input wire logic wake_o,
  input wire logic irq_service_o,
  input wire logic [8:0] blk_rst_n_o,
  input wire logic [8:0] blk_clk_en_o,
  input wire logic [8:0] blk_wr_en_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  logic [8:0] ticks;
  // Ticks seen while waking; cleared in STOP so each wake counts afresh.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) ticks <= 9'h000;
    else if (osc_stop_o) ticks <= 9'h000;
    else if (ls_tick_i && !periph_clk_on_o) ticks <= ticks + 9'h001;
  end
  sequence s_wake;
    !cpu_halt_o && wake_o;
  endsequence
  property p_osc;
    osc_stop_o |-> cpu_halt_o && !periph_clk_on_o;
  endproperty
  a_osc: assert property (p_osc) else $error("stop mode outputs wrong");
  property p_halt_wake;
    cpu_halt_o && periph_clk_on_o && !osc_stop_o && (wdt_irq_i || irq_pending_i) |=> s_wake;
  endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("halt not left");
  property p_stop_wake;
    osc_stop_o && irq_pending_i |=> !osc_stop_o;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stop not left");
  property p_ls_wake;
    $rose(periph_clk_on_o) && !$past(osc_stop_o) |-> ticks >= LS_TICKS && ticks <= LS_TICKS + 1;
  endproperty
  a_ls_wake: assert property (p_ls_wake) else $error("wake tick count wrong");
  property p_pulse;
    wake_o |=> !wake_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("wake pulse too long");
  property p_svc;
    irq_service_o |-> s_wake;
  endproperty
  a_svc: assert property (p_svc) else $error("service without wake");
  property p_no_svc;
    wake_o && !$past(master_irq_enable_i) && !$past(wdt_irq_i) |-> !irq_service_o;
  endproperty
  a_no_svc: assert property (p_no_svc) else $error("service while masked");
  property p_gate;
    blk_clk_en_o == blk_rst_n_o && blk_wr_en_o == blk_rst_n_o;
  endproperty
  a_gate: assert property (p_gate) else $error("gates disagree");
endmodule : sbc_ctrl_chk
bind sbc_ctrl sbc_ctrl_chk #(.LS_TICKS(LS_TICKS)) u_chk (.ref_clk_i(ref_clk_i),
  .nrst_i(nrst_i), .irq_pending_i(irq_pending_i), .wdt_irq_i(wdt_irq_i),
  .master_irq_enable_i(master_irq_enable_i), .ls_tick_i(ls_tick_i),
  .cpu_halt_o(cpu_halt_o), .osc_stop_o(osc_stop_o), .periph_clk_on_o(periph_clk_on_o),
  .wake_o(wake_o), .irq_service_o(irq_service_o), .blk_rst_n_o(blk_rst_n_o),
  .blk_clk_en_o(blk_clk_en_o), .blk_wr_en_o(blk_wr_en_o));

// file: dv/sbc_far_end.sv
/*
  Far-side model: interrupt controller and low-speed oscillator.
  Assumes the bench sets request and enable levels after a rising edge.
*/
`timescale 1ns/10ps
module sbc_far_end #(
  parameter int TICK_DIV = 5
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Controls.
  input wire logic osc_stop_i,
  input wire logic irq_req_i,
  input wire logic irq_en_i,
  // Outputs.
  output logic ls_tick_o,
  output logic irq_pending_o
);
  int div;
  // Pending means enable and request both set, whatever the master enable.
  assign irq_pending_o = irq_req_i & irq_en_i;
  // The oscillator is dead while stopped, so no ticks reach the counter.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div <= 0;
      ls_tick_o <= 1'b0;
    end else begin
      div <= (osc_stop_i || div == TICK_DIV - 1) ? 0 : div + 1;
      ls_tick_o <= !osc_stop_i && div == TICK_DIV - 1;
    end
  end
endmodule : sbc_far_end

// file: dv/testbench.sv
/*
  Self-checking bench: AHB-Lite register tasks and mode scenarios.
  Assumes the far-end model and a shortened wake count of four ticks.
*/
`timescale 1ns/10ps
module testbench;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic wdt = 1'b0;
  logic master_interrupt_enable = 1'b0;
  logic irq_req = 1'b0;
  logic irq_en = 1'b0;
  logic [31:0] hrdata;
  logic hready, hresp, pend, tick, halt, ostop, pclk, wake, svc;
  logic [8:0] brst, bclk, bwr;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] v;
  logic [15:0] bidx [4] = '{sbc_pkg::IDX_SER, sbc_pkg::IDX_CONV, sbc_pkg::IDX_TMR,
    sbc_pkg::IDX_PWM};
  logic [7:0] bmask [4] = '{sbc_pkg::MASK_SER, sbc_pkg::MASK_CONV, sbc_pkg::MASK_TMR,
    sbc_pkg::MASK_PWM};
  logic [8:0] bexp [4] = '{9'h1FE, 9'h1FD, 9'h103, 9'h0FF};
  // A small wake count keeps the low-speed wake short.
  sbc_ctrl #(.LS_TICKS(4)) dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .hsel_i(1'b1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .irq_pending_i(pend), .wdt_irq_i(wdt), .master_irq_enable_i(master_interrupt_enable),
    .ls_tick_i(tick), .cpu_halt_o(halt), .osc_stop_o(ostop), .periph_clk_on_o(pclk),
    .wake_o(wake), .irq_service_o(svc), .blk_rst_n_o(brst), .blk_clk_en_o(bclk),
    .blk_wr_en_o(bwr));
  sbc_far_end far (.clk_i(ref_clk_i), .rst_n_i(nrst_i), .osc_stop_i(ostop),
    .irq_req_i(irq_req), .irq_en_i(irq_en), .ls_tick_o(tick), .irq_pending_o(pend));
  // Clock and hang guard.
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  function automatic logic [31:0] adr(input logic [15:0] idx);
    return {14'h0, idx, 2'h0};
  endfunction : adr
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_pin(input logic [8:0] got, input logic [8:0] exp);
    chk_reg({23'h0, got}, {23'h0, exp});
  endtask : chk_pin
  // One bus transfer; read data is taken at the data-phase edge.
  task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
    @(posedge ref_clk_i);
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge ref_clk_i); while (hready !== 1'b1);
    v = hrdata;
  endtask : xfer
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 8'h00);
    chk_reg(v, exp);
  endtask : rdc
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : step
  task automatic results;
    $display("mismatches %0d comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  // Main sequence.
  initial begin
    repeat (3) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rdc(adr(sbc_pkg::IDX_KEY), 32'h0);
    rdc(adr(sbc_pkg::IDX_SBY), 32'h0);
    for (int i = 0; i < 4; i++) begin
      rdc(adr(bidx[i]), 32'h0);
      xfer(adr(bidx[i]), 1'b1, 8'hFF);
      rdc(adr(bidx[i]), {24'h0, bmask[i]});
      step(2);
      chk_pin(brst, bexp[i]);
      xfer(adr(bidx[i]), 1'b1, 8'h00);
      step(2);
      chk_pin(brst, 9'h1FF);
    end
    xfer(32'h0010_0000, 1'b1, 8'hFF);
    rdc(32'h0010_0000, 32'h0);
    xfer(adr(sbc_pkg::IDX_KEY), 1'b1, 8'h51);
    xfer(adr(sbc_pkg::IDX_KEY), 1'b1, 8'h31);
    xfer(adr(sbc_pkg::IDX_KEY), 1'b1, 8'hA0);
    xfer(adr(sbc_pkg::IDX_STAT), 1'b0, 8'h00);
    chk_pin(v[0], 1'b0);
    @(posedge ref_clk_i);
    irq_en <= 1'b1;
    irq_req <= 1'b1;
    xfer(adr(sbc_pkg::IDX_KEY), 1'b1, 8'h5F);
    xfer(adr(sbc_pkg::IDX_KEY), 1'b1, 8'hA0);
    xfer(adr(sbc_pkg::IDX_STAT), 1'b0, 8'h00);
    chk_pin(v[0], 1'b0);
    xfer(adr(sbc_pkg::IDX_SBY), 1'b1, 8'h01);
    step(2);
    chk_pin(halt, 1'b0);
    irq_req <= 1'b0;
    xfer(adr(sbc_pkg::IDX_KEY), 1'b1, 8'h5F);
    rdc(adr(sbc_pkg::IDX_CFG), 32'h0);
    xfer(adr(sbc_pkg::IDX_KEY), 1'b1, 8'hA3);
    xfer(adr(sbc_pkg::IDX_STAT), 1'b0, 8'h00);
    chk_pin(v[0], 1'b1);
    xfer(adr(sbc_pkg::IDX_SBY), 1'b1, 8'h01);
    step(1);
    chk_pin({halt, pclk}, 2'h3);
    @(posedge ref_clk_i);
    wdt <= 1'b1;
    step(2);
    chk_pin(halt, 1'b0);
    wdt <= 1'b0;
    rdc(adr(sbc_pkg::IDX_SBY), 32'h0);
    xfer(adr(sbc_pkg::IDX_SBY), 1'b1, 8'h03);
    step(3);
    chk_pin({halt, ostop}, 2'h0);
    for (int k = 0; k < 2; k++) begin
      if (k == 1) xfer(adr(sbc_pkg::IDX_CFG), 1'b1, 8'h01);
      xfer(adr(sbc_pkg::IDX_KEY), 1'b1, 8'h50);
      xfer(adr(sbc_pkg::IDX_KEY), 1'b1, 8'hA0);
      xfer(adr(sbc_pkg::IDX_SBY), 1'b1, 8'h02);
      step(1);
      chk_pin(ostop, 1'b0);
      step(1);
      chk_pin({ostop, pclk}, 2'h2);
      xfer(adr(sbc_pkg::IDX_STAT), 1'b0, 8'h00);
      chk_pin(v[0], 1'b0);
      @(posedge ref_clk_i);
      master_interrupt_enable <= k[0];
      irq_req <= 1'b1;
      for (int n = 0; n < 200 && !pclk; n++) step(1);
      chk_pin({ostop, halt, pclk, wake, svc}, {4'h3, k[0]});
      irq_req <= 1'b0;
    end
    xfer(adr(sbc_pkg::IDX_SBY), 1'b1, 8'h02);
    step(4);
    chk_pin(ostop, 1'b0);
    results();
  end
endmodule : testbench
